// file: spi_frame_defs.vh
`ifndef SPI_FRAME_DEFS_VH
`define SPI_FRAME_DEFS_VH
`define FRM_WIDTH 16
`define FRM_RW_BIT 15
`define FRM_PTR_HI 14
`define FRM_PTR_LO 12
`define FRM_PAY_HI 11
`define FRM_PAY_LO 0
`define FRM_PAR_BIT 15
`define FRM_UPPER_HI 15
`define FRM_UPPER_LO 8
`define FRM_LOWER_HI 7
`define FRM_LOWER_LO 0
`define FRM_RW_READ 1'h0
`define FRM_RW_WRITE 1'h1
`define FRM_BYTE_BITS 4'h8
`define DIAG_PTR 3'h0
`define BIT_CNT_W 6
`endif

// file: spi_edge_sync.v
module spi_edge_sync (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire pin_in,
    output reg level_out,
    output wire rise_out,
    output wire fall_out
);
    reg meta_r;
    reg prev_r;
    // Two flops before any logic
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            meta_r <= 1'b0;
            level_out <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin_in;
            level_out <= meta_r;
            prev_r <= level_out;
        end
    end
    assign rise_out = level_out & ~prev_r;
    assign fall_out = ~level_out & prev_r;
endmodule

// file: spi_frame_protocol_engine.v
`include "spi_frame_defs.vh"
//
// Contract
// - Every selected frame shifts a full reply out while the command shifts in.
// - A read request is answered with the register contents in the next frame.
// - Input frames carry write/read in bit 15, pointer in 14:12, payload in 11:0.
// - A write reaches the register only at the rising edge of chip select.
// - After a write the next reply carries data of the register written.
// - Replies carry parity in bit 15, pointer in 14:12, contents in 11:0.
// - Parity is 1 when pointer and data hold an odd count of ones, else 0.
// - The first reply after reset is the short diagnosis and status reply.
// - In split mode the upper byte runs after 8 bits and fills this lower reply byte.
// - In split mode the lower byte runs at frame end and fills the next upper byte.
// - The protocol is chosen per frame from the command, freely interleaved.
// - Transfer only while chip select is low; otherwise output is released.
// - Input sampled MSB first on falling clock, output changes on rising clock.
// - A frame is decoded only when its clock count is a multiple of eight.
module spi_frame_protocol_engine #(
    parameter FRAME_BITS = 16
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire spi_cs_n_in,
    input wire spi_sclk_in,
    input wire spi_si_in,
    output reg spi_so_out,
    output reg spi_so_oe_n_out,
    // Split-mode selection of an upper byte, from command decode
    input wire split_mode_in,
    // Register access toward the register file
    output reg [2:0] rd_ptr_out,
    output reg rd_req_out,
    input wire [11:0] rd_data_in,
    output reg [2:0] wr_ptr_out,
    output reg [11:0] wr_data_out,
    output reg wr_stb_out,
    // Short diagnosis and status payload
    input wire [11:0] short_diag_status_reply_in,
    // Split-byte command execution
    output reg [7:0] upper_cmd_out,
    output reg upper_stb_out,
    input wire [7:0] upper_result_in,
    output reg [7:0] lower_cmd_out,
    output reg lower_stb_out,
    input wire [7:0] lower_result_in,
    output reg frame_err_out
);
    wire cs_lvl;
    wire cs_rise;
    wire cs_fall;
    wire sclk_lvl;
    wire sclk_rise;
    wire sclk_fall;
    wire si_lvl;
    reg [FRAME_BITS-1:0] rx_r;
    reg [FRAME_BITS-1:0] tx_r;
    reg [FRAME_BITS-1:0] reply_r;
    reg [`BIT_CNT_W-1:0] cnt_r;
    reg split_r;
    reg [7:0] next_upper_r;
    reg upper_pend_r;
    reg [2:0] upper_wait_r;
    reg [15:0] reply_nxt;
    reg link_ready_r;
    wire frame_start;
    wire frame_end;
    wire in_frame;

    function parity15;
        input [14:0] v;
        begin
            parity15 = ^v;
        end
    endfunction

    // Non-empty whole number of bytes
    function byte_aligned;
        input [`BIT_CNT_W-1:0] c;
        begin
            byte_aligned = (c[2:0] == 3'h0) && (c != {`BIT_CNT_W{1'b0}});
        end
    endfunction

    function cnt_is;
        input [`BIT_CNT_W-1:0] c;
        input [3:0] v;
        begin
            cnt_is = (c == {{(`BIT_CNT_W-4){1'b0}}, v});
        end
    endfunction

    function [15:0] diag_frame;
        input [11:0] d;
        begin
            diag_frame = {parity15({`DIAG_PTR, d}), `DIAG_PTR, d};
        end
    endfunction

    spi_edge_sync u_cs (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(spi_cs_n_in),
        .level_out(cs_lvl),
        .rise_out(cs_rise),
        .fall_out(cs_fall)
    );
    spi_edge_sync u_sclk (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(spi_sclk_in),
        .level_out(sclk_lvl),
        .rise_out(sclk_rise),
        .fall_out(sclk_fall)
    );
    spi_edge_sync u_si (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(spi_si_in),
        .level_out(si_lvl),
        .rise_out(),
        .fall_out()
    );

    // Syncs leave reset low, which looks like a select; wait for idle high
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
            link_ready_r <= 1'b0;
        else if (cs_lvl)
            link_ready_r <= 1'b1;
    end
    // No false frame end right after reset
    assign frame_start = cs_fall & link_ready_r;
    assign frame_end = cs_rise & link_ready_r;
    assign in_frame = ~cs_lvl & link_ready_r;

    // Next reply: 16-bit form with parity over pointer and data, or next_upper_r over a zero byte after a split frame
    always @*
    begin
        reply_nxt = 16'h0000;
        reply_nxt[`FRM_PTR_HI:`FRM_PTR_LO] = rd_ptr_out;
        reply_nxt[`FRM_PAY_HI:`FRM_PAY_LO] = rd_data_in;
        reply_nxt[`FRM_PAR_BIT] = parity15(reply_nxt[14:0]);
        if (split_r)
        begin
            reply_nxt[`FRM_UPPER_HI:`FRM_UPPER_LO] = next_upper_r;
            reply_nxt[`FRM_LOWER_HI:`FRM_LOWER_LO] = 8'h00;
        end
    end

    // Receive: falling link clock, MSB first
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            rx_r <= {FRAME_BITS{1'b0}};
            cnt_r <= {`BIT_CNT_W{1'b0}};
            split_r <= 1'b0;
        end
        else if (frame_start)
        begin
            cnt_r <= {`BIT_CNT_W{1'b0}};
        end
        else if (in_frame && sclk_fall)
        begin
            rx_r <= {rx_r[FRAME_BITS-2:0], si_lvl};
            cnt_r <= cnt_r + {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
            // Eighth bit picks the protocol of this frame
            if (cnt_is(cnt_r, 4'h7))
                split_r <= split_mode_in;
        end
    end

    // Upper byte runs as soon as its eighth bit lands
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            upper_cmd_out <= 8'h00;
            upper_stb_out <= 1'b0;
        end
        else
        begin
            upper_stb_out <= 1'b0;
            if (in_frame && sclk_fall && cnt_is(cnt_r, 4'h7) && split_mode_in)
            begin
                upper_cmd_out <= {rx_r[6:0], si_lvl};
                upper_stb_out <= 1'b1;
            end
        end
    end

    // Frame end: decode only byte-aligned frames
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            rd_ptr_out <= `DIAG_PTR;
            rd_req_out <= 1'b0;
            wr_ptr_out <= 3'h0;
            wr_data_out <= 12'h000;
            wr_stb_out <= 1'b0;
            lower_cmd_out <= 8'h00;
            lower_stb_out <= 1'b0;
            frame_err_out <= 1'b0;
            upper_pend_r <= 1'b0;
            upper_wait_r <= 3'h0;
        end
        else
        begin
            wr_stb_out <= 1'b0;
            lower_stb_out <= 1'b0;
            rd_req_out <= 1'b0;
            frame_err_out <= 1'b0;
            if (upper_wait_r != 3'h0)
                upper_wait_r <= upper_wait_r - 3'h1;
            if (frame_end)
            begin
                upper_pend_r <= 1'b1;
                // Refused frames keep pointer and registers as they were
                if (!byte_aligned(cnt_r))
                    frame_err_out <= 1'b1;
                else if (split_r)
                begin
                    lower_cmd_out <= rx_r[`FRM_LOWER_HI:`FRM_LOWER_LO];
                    lower_stb_out <= 1'b1;
                    upper_wait_r <= 3'h2;
                end
                else
                begin
                    rd_ptr_out <= rx_r[`FRM_PTR_HI:`FRM_PTR_LO];
                    rd_req_out <= 1'b1;
                    if (rx_r[`FRM_RW_BIT] == `FRM_RW_WRITE)
                    begin
                        wr_ptr_out <= rx_r[`FRM_PTR_HI:`FRM_PTR_LO];
                        wr_data_out <= rx_r[`FRM_PAY_HI:`FRM_PAY_LO];
                        wr_stb_out <= 1'b1;
                    end
                    upper_wait_r <= 3'h2;
                end
            end
        end
    end

    // Reply for the next frame; lower result first, then the whole word
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            next_upper_r <= 8'h00;
            reply_r <= {FRAME_BITS{1'b0}};
        end
        else
        begin
            if (upper_wait_r == 3'h2 && split_r)
                next_upper_r <= lower_result_in;
            if (upper_wait_r == 3'h1)
                reply_r <= reply_nxt;
        end
    end

    // Transmit: load at select, move on rising link clock
    always @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            tx_r <= {FRAME_BITS{1'b0}};
            spi_so_out <= 1'b0;
            spi_so_oe_n_out <= 1'b1;
        end
        else if (frame_start)
        begin
            // Short diag until the first frame has ended
            if (upper_pend_r)
            begin
                tx_r <= reply_r;
                spi_so_out <= reply_r[FRAME_BITS-1];
            end
            else
            begin
                tx_r <= diag_frame(short_diag_status_reply_in);
                spi_so_out <= parity15({`DIAG_PTR, short_diag_status_reply_in});
            end
            spi_so_oe_n_out <= 1'b0;
        end
        else if (frame_end)
        begin
            spi_so_oe_n_out <= 1'b1;
        end
        else if (in_frame && sclk_rise && (cnt_r != {`BIT_CNT_W{1'b0}}))
        begin
            // First rising edge keeps bit 15, host samples on the falling one
            if (split_r && cnt_is(cnt_r, 4'h8))
            begin
                tx_r <= {upper_result_in, 8'h00};
                spi_so_out <= upper_result_in[7];
            end
            else
            begin
                tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
                spi_so_out <= tx_r[FRAME_BITS-2];
            end
        end
    end
endmodule

// file: spi_frame_checker.sv
module spi_frame_checker #(parameter FRAME_BITS = 16) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire spi_cs_n_in,
    input wire spi_sclk_in,
    input wire split_mode_in,
    input wire spi_so_out,
    input wire spi_so_oe_n_out,
    input wire rd_req_out,
    input wire wr_stb_out,
    input wire upper_stb_out,
    input wire lower_stb_out,
    input wire frame_err_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    write_at_end_a: assert property (wr_stb_out |-> spi_cs_n_in ##1 !wr_stb_out)
        else $error("write strobe not a pulse at frame end");
    read_at_end_a: assert property (rd_req_out |-> spi_cs_n_in ##1 !rd_req_out)
        else $error("read request not a pulse at frame end");
    so_release_a: assert property (spi_cs_n_in [*8] |-> spi_so_oe_n_out)
        else $error("output driven while deselected");
    so_drive_a: assert property (!spi_cs_n_in [*8] |-> !spi_so_oe_n_out)
        else $error("output not driven in frame");
    upper_mid_a: assert property (upper_stb_out |-> !spi_cs_n_in && split_mode_in)
        else $error("upper command outside split frame");
    lower_end_a: assert property (lower_stb_out |-> spi_cs_n_in && !frame_err_out)
        else $error("lower command not at good frame end");
    so_hold_a: assert property ($fell(spi_sclk_in) && !spi_cs_n_in |-> $stable(spi_so_out) [*4])
        else $error("output moved after falling clock");
    bad_count_a: assert property (frame_err_out |-> !wr_stb_out ##1 !wr_stb_out)
        else $error("write on miscounted frame");
endmodule
bind spi_frame_protocol_engine spi_frame_checker #(.FRAME_BITS(FRAME_BITS)) i_chk (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .spi_cs_n_in(spi_cs_n_in),
    .spi_sclk_in(spi_sclk_in), .split_mode_in(split_mode_in), .spi_so_out(spi_so_out),
    .spi_so_oe_n_out(spi_so_oe_n_out), .rd_req_out(rd_req_out), .wr_stb_out(wr_stb_out),
    .upper_stb_out(upper_stb_out), .lower_stb_out(lower_stb_out),
    .frame_err_out(frame_err_out));

// file: spi_host_model.sv
module spi_host_model (
    output logic cs_n_out,
    output logic sclk_out,
    output logic si_out,
    input wire logic so_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
    end
    // Clock idles low at select edges, bits MSB first, moved on rising edges
    task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        rx = 16'h0000;
        si_out = tx[15];
        cs_n_out = 1'b0;
        #64;
        for (int i = 0; i < nb; i++)
        begin
            sclk_out = 1'b1;
            if (i > 0) si_out = tx[15 - i];
            #32;
            rx = {rx[14:0], so_in};
            sclk_out = 1'b0;
            #32;
        end
        cs_n_out = 1'b1;
        si_out = ~si_out; // Stale bit must not look valid
        #100;
    endtask
endmodule

// file: spi_frame_protocol_engine_test.sv
module spi_frame_protocol_engine_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, split = 1'b0;
    logic [11:0] rdd = 12'h000, diag = 12'hA5C, wd;
    logic [7:0] upr = 8'h00, lwr = 8'h00, lc;
    logic [15:0] rx;
    logic [2:0] wp;
    wire cs_n, sclk, si, so, oe_n, rd_req, wr_stb, ustb, lstb, ferr;
    wire [2:0] rd_ptr, wr_ptr;
    wire [11:0] wr_data;
    wire [7:0] ucmd, lcmd;
    int failures = 0, n_checks = 0, n_wr = 0, n_err = 0;
    always #2.5 clk = ~clk;
    always @(negedge clk)
    begin
        rdd <= {rd_ptr, 9'h0C3};
        upr <= ~ucmd;
        lwr <= lcmd ^ 8'h3C;
    end
    always @(posedge clk)
    begin
        if (wr_stb) begin n_wr++; wp <= wr_ptr; wd <= wr_data; end
        if (ferr) n_err++;
        if (lstb) lc <= lcmd;
    end
    // Released output reads as the inverse of its last bit
    spi_host_model i_host (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si),
        .so_in(oe_n ? ~so : so));
    spi_frame_protocol_engine #(.FRAME_BITS(16)) i_dut (.ref_clk_in(clk), .reset_n_in(rst_n),
        .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_si_in(si), .spi_so_out(so),
        .spi_so_oe_n_out(oe_n), .split_mode_in(split), .rd_ptr_out(rd_ptr),
        .rd_req_out(rd_req), .rd_data_in(rdd), .wr_ptr_out(wr_ptr), .wr_data_out(wr_data),
        .wr_stb_out(wr_stb), .short_diag_status_reply_in(diag), .upper_cmd_out(ucmd),
        .upper_stb_out(ustb), .upper_result_in(upr), .lower_cmd_out(lcmd),
        .lower_stb_out(lstb), .lower_result_in(lwr), .frame_err_out(ferr));
    function automatic logic [15:0] rep(input logic [2:0] p, input logic [11:0] d);
        rep = {^{p, d}, p, d};
    endfunction
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, s); end
    endtask
    task conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_first;
        i_host.xfer({1'b1, 3'h3, 12'h123}, 16, rx);
        chk("first reply", rep(3'h0, diag), rx);
        chk("write", {1'b0, 3'h3, 12'h123}, {1'b0, wp, wd});
    endtask
    task t_read;
        i_host.xfer({1'b0, 3'h5, 12'hFFF}, 16, rx);
        chk("write reply", rep(3'h3, {3'h3, 9'h0C3}), rx);
        i_host.xfer(16'h0000, 16, rx);
        chk("read reply", rep(3'h5, {3'h5, 9'h0C3}), rx);
        chk("writes", 16'h0001, n_wr[15:0]);
    endtask
    task t_split;
        split = 1'b1;
        i_host.xfer(16'hC45B, 16, rx);
        chk("lower now", {8'h00, ~8'hC4}, {8'h00, rx[7:0]});
        chk("lower cmd", 16'h005B, {8'h00, lc});
        i_host.xfer(16'h8100, 16, rx);
        chk("split reply", {8'h5B ^ 8'h3C, ~8'h81}, rx);
        split = 1'b0;
        i_host.xfer({1'b0, 3'h6, 12'h000}, 16, rx);
        i_host.xfer(16'h0000, 16, rx);
        chk("mixed read", rep(3'h6, {3'h6, 9'h0C3}), rx);
    endtask
    task t_badcnt;
        i_host.xfer({1'b1, 3'h2, 12'hABC}, 12, rx);
        chk("bad frame write", 16'h0001, n_wr[15:0]);
        chk("bad frame flag", 16'h0001, n_err[15:0]);
    endtask
    initial
    begin
        #50us;
        failures++;
        conclude;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_first;
        t_read;
        t_split;
        t_badcnt;
        conclude;
    end
endmodule
